//--- spa_pkg.sv
// shared constants for the supply protection and alarm control block
package spa_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TENTH_S_NS    = 100_000_000;
    localparam int unsigned TICK_DEFAULT  = TENTH_S_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_S        = 3;
    localparam logic [4:0]  HOLD_TICKS    = 5'(HOLD_S * 10);

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_FOLD_MODE  = 4'h0;
    localparam logic [3:0] CMD_FOLD_DELAY = 4'h1;
    localparam logic [3:0] CMD_PROT_CLEAR = 4'h2;
    localparam logic [3:0] CMD_OTP_LATCH  = 4'h3;
    localparam logic [3:0] CMD_LOOP       = 4'h4;
    localparam logic [3:0] CMD_INTERLOCK  = 4'h5;
    localparam logic [3:0] CMD_SAVE       = 4'h6;
    localparam logic [3:0] CMD_RECALL     = 4'h7;
    localparam logic [3:0] CMD_LEVEL      = 4'h8;
    localparam logic [3:0] CMD_SOURCE     = 4'h9;
    localparam logic [3:0] CMD_MASK       = 4'hA;
    localparam logic [3:0] CMD_SHDN_POL   = 4'hB;

    // ------------------------------------------------------------
    // encodings and ranges
    // ------------------------------------------------------------
    localparam logic [1:0] FOLD_NONE = 2'h0;
    localparam logic [1:0] FOLD_CC   = 2'h1;
    localparam logic [1:0] FOLD_CV   = 2'h2;

    localparam logic [2:0] SRC_LOCAL      = 3'h0;
    localparam logic [2:0] SRC_MAX        = 3'h4;

    localparam logic [8:0] DELAY_MIN   = 9'h005;
    localparam logic [8:0] DELAY_MAX   = 9'h1F4;
    localparam logic [8:0] DELAY_RESET = 9'h005;

    localparam logic [6:0] LEVEL_MIN   = 7'h14;
    localparam logic [6:0] LEVEL_MAX   = 7'h64;
    localparam logic [6:0] LEVEL_RESET = 7'h64;

    localparam logic [1:0] SLOT_MIN = 2'h1;
    localparam logic [1:0] SLOT_MAX = 2'h3;

    // ------------------------------------------------------------
    // alarm mask layout
    // ------------------------------------------------------------
    localparam int unsigned MASK_W    = 11;
    localparam int unsigned BIT_AC    = 0;
    localparam int unsigned BIT_OTP   = 1;
    localparam int unsigned BIT_FAN   = 3;
    localparam int unsigned BIT_ILK   = 5;
    localparam int unsigned BIT_OV    = 6;
    localparam int unsigned BIT_OC    = 7;
    localparam int unsigned BIT_FOLD  = 8;
    localparam int unsigned BIT_SHDN  = 9;
    localparam int unsigned BIT_UV    = 10;
    localparam logic [10:0] MASK_FIXED_ONES = 11'h0E3;
    localparam logic [10:0] MASK_WRITABLE   = 11'h708;
    localparam logic [10:0] MASK_RESET      = 11'h7EB;

    localparam int unsigned SET_W = 47;
endpackage

//--- spa_slot_mem.sv
// three-slot user settings store with registered read
`timescale 1ns/1ps
`default_nettype none
module spa_slot_mem #(
    parameter int unsigned WIDTH = 47,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             i_clk,   // system clock
    input  wire logic             i_rst_n, // async reset, active low
    input  wire logic [WIDTH-1:0] i_init,  // contents after reset
    input  wire logic             i_we,    // write strobe
    input  wire logic [1:0]       i_addr,  // slot index
    input  wire logic [WIDTH-1:0] i_wdata, // write data
    output logic      [WIDTH-1:0] o_rdata  // read data, one cycle late
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // slots hold nothing sensible before a save; unwritten slots recall i_init
    logic [DEPTH-1:0] written;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            written <= '0;
        end else if (i_we) begin
            written[i_addr] <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= written[i_addr] ? mem[i_addr] : i_init;
        end
    end
endmodule
`default_nettype wire

//--- spa_top.sv
// protection, alarm mask and settings control for a programmable supply
`timescale 1ns/1ps
`default_nettype none
module spa_top import spa_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_DEFAULT
) (
    input  wire logic        i_clk,             // 200 MHz clock
    input  wire logic        i_rst_n,           // async reset, active low
    input  wire logic        i_cmd_valid,       // command strobe
    input  wire logic        i_cmd_query,       // 1 = query, 0 = set
    input  wire logic [3:0]  i_cmd_code,        // command code
    input  wire logic [1:0]  i_cmd_sel,         // level / source selector
    input  wire logic [10:0] i_cmd_data,        // command argument
    input  wire logic        i_out_on,          // output enabled
    input  wire logic        i_reg_cc,          // constant_current_regulation
    input  wire logic        i_reg_cv,          // constant_voltage_regulation
    input  wire logic        i_adjust_held,     // adjust control pressed
    input  wire logic        i_ac_fault,        // line fail
    input  wire logic        i_otp_fault,       // over temperature
    input  wire logic        i_fan_fault,       // fan stopped
    input  wire logic        i_ilk_fault,       // interlock open
    input  wire logic        i_ov_fault,        // over_voltage_alarm source
    input  wire logic        i_oc_fault,        // over_current_alarm source
    input  wire logic        i_shdn_fault,      // external shutdown asserted
    input  wire logic        i_uv_fault,        // under_voltage_alarm source
    output logic             o_rsp_valid,       // answer strobe
    output logic             o_rsp_err,         // command refused
    output logic      [10:0] o_rsp_data,        // query answer
    output logic             o_fold_shutdown,   // foldback shutdown in force
    output logic             o_otp_alarm,       // over-temperature alarm
    output logic             o_ilk_alarm,       // interlock alarm
    output logic      [10:0] o_alarm_status,    // unmasked alarms
    output logic             o_shdn_active_low, // effective shutdown polarity
    output logic             o_loop_en,         // feedback_fault_protection enable
    output logic             o_ilk_en,          // interlock enable
    output logic      [2:0]  o_vsrc,            // voltage control source
    output logic      [2:0]  o_isrc,            // current control source
    output logic      [27:0] o_levels           // {v, v iso, i, i iso} full scale
);
    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    logic [31:0] pre_cnt;
    logic        tick;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            tick    <= (pre_cnt == 32'(TICK_CYCLES - 1));
            pre_cnt <= (pre_cnt == 32'(TICK_CYCLES - 1)) ? '0 : pre_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // settings and command decode
    // ------------------------------------------------------------
    logic [1:0]  fold_mode;
    logic [8:0]  fold_delay;
    logic [10:0] mask;
    logic        otp_latch;
    logic        user_pol;
    logic        recall_pend;
    logic [SET_W-1:0] cur_set;
    logic [SET_W-1:0] slot_data;
    logic        wr;
    logic        cmd_ok;

    assign wr = i_cmd_valid && !i_cmd_query;
    assign cur_set = {fold_mode, fold_delay, o_levels, o_vsrc, o_isrc, user_pol, o_loop_en};

    always_comb begin
        cmd_ok = 1'b1;
        if (wr) begin
            case (i_cmd_code)
                CMD_FOLD_MODE:  cmd_ok = (i_cmd_data[1:0] <= FOLD_CV);
                CMD_FOLD_DELAY: cmd_ok = (i_cmd_data[8:0] >= DELAY_MIN)
                                      && (i_cmd_data[8:0] <= DELAY_MAX)
                                      && (i_cmd_data[10:9] == 2'h0);
                CMD_SAVE,
                CMD_RECALL:     cmd_ok = (i_cmd_data[1:0] >= SLOT_MIN)
                                      && (i_cmd_data[10:2] == 9'h000);
                CMD_LEVEL:      cmd_ok = (i_cmd_data[6:0] >= LEVEL_MIN)
                                      && (i_cmd_data[6:0] <= LEVEL_MAX)
                                      && (i_cmd_data[10:7] == 4'h0);
                CMD_SOURCE:     cmd_ok = (i_cmd_data[2:0] <= SRC_MAX) && !i_cmd_sel[1];
                CMD_MASK,
                CMD_PROT_CLEAR,
                CMD_OTP_LATCH,
                CMD_LOOP,
                CMD_INTERLOCK,
                CMD_SHDN_POL:   cmd_ok = 1'b1;
                default:        cmd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fold_mode   <= FOLD_NONE;
            fold_delay  <= DELAY_RESET;
            mask        <= MASK_RESET;
            otp_latch   <= 1'b0;
            o_loop_en   <= 1'b0;
            o_ilk_en    <= 1'b0;
            user_pol    <= 1'b0;
            o_vsrc      <= SRC_LOCAL;
            o_isrc      <= SRC_LOCAL;
            o_levels    <= {4{LEVEL_RESET}};
            recall_pend <= 1'b0;
        end else begin
            recall_pend <= wr && cmd_ok && (i_cmd_code == CMD_RECALL);
            if (recall_pend) begin
                {fold_mode, fold_delay, o_levels, o_vsrc, o_isrc, user_pol, o_loop_en}
                    <= slot_data;
            end else if (wr && cmd_ok) begin
                case (i_cmd_code)
                    CMD_FOLD_MODE:  fold_mode  <= i_cmd_data[1:0];
                    CMD_FOLD_DELAY: fold_delay <= i_cmd_data[8:0];
                    CMD_OTP_LATCH:  otp_latch  <= i_cmd_data[0];
                    CMD_LOOP:       o_loop_en  <= i_cmd_data[0];
                    CMD_INTERLOCK:  o_ilk_en   <= i_cmd_data[0];
                    CMD_SHDN_POL:   user_pol   <= i_cmd_data[0];
                    CMD_MASK:       mask <= (i_cmd_data & MASK_WRITABLE)
                                          | MASK_FIXED_ONES;
                    CMD_LEVEL:      o_levels[7*(3-i_cmd_sel) +: 7]
                                        <= i_cmd_data[6:0];
                    CMD_SOURCE: begin
                        if (i_cmd_sel[0]) begin
                            o_isrc <= i_cmd_data[2:0];
                        end else begin
                            o_vsrc <= i_cmd_data[2:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    spa_slot_mem #(
        .WIDTH (SET_W),
        .DEPTH (4)
    ) u_slots (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_init  (cur_set),
        .i_we    (wr && cmd_ok && (i_cmd_code == CMD_SAVE)),
        .i_addr  (i_cmd_data[1:0]),
        .i_wdata (cur_set),
        .o_rdata (slot_data)
    );

    // ------------------------------------------------------------
    // answers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_err   <= 1'b0;
            o_rsp_data  <= '0;
        end else begin
            o_rsp_valid <= i_cmd_valid;
            o_rsp_err   <= i_cmd_valid && !cmd_ok;
            o_rsp_data  <= '0;
            if (i_cmd_valid && i_cmd_query) begin
                case (i_cmd_code)
                    CMD_FOLD_MODE:  o_rsp_data <= {9'h000, fold_mode};
                    CMD_FOLD_DELAY: o_rsp_data <= {2'h0, fold_delay};
                    CMD_OTP_LATCH:  o_rsp_data <= {10'h000, otp_latch};
                    CMD_LOOP:       o_rsp_data <= {10'h000, o_loop_en};
                    CMD_INTERLOCK:  o_rsp_data <= {10'h000, o_ilk_en};
                    CMD_SHDN_POL:   o_rsp_data <= {10'h000, user_pol};
                    CMD_MASK:       o_rsp_data <= mask;
                    CMD_LEVEL:      o_rsp_data <= {4'h0, o_levels[7*(3-i_cmd_sel) +: 7]};
                    CMD_SOURCE:     o_rsp_data <= {8'h00, i_cmd_sel[0] ? o_isrc : o_vsrc};
                    default:        o_rsp_data <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // foldback
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FB_IDLE, FB_COUNT, FB_TRIP} spa_fold_type;
    spa_fold_type fb_state;
    logic [8:0] fb_cnt;
    logic [4:0] adj_cnt;
    logic       fb_match;
    logic       clr_cmd;
    logic       release_ok;

    // a masked foldback neither counts nor trips
    assign fb_match = i_out_on && mask[BIT_FOLD]
                   && (((fold_mode == FOLD_CC) && i_reg_cc)
                    || ((fold_mode == FOLD_CV) && i_reg_cv));
    assign clr_cmd    = wr && (i_cmd_code == CMD_PROT_CLEAR);
    assign release_ok = clr_cmd && (adj_cnt == HOLD_TICKS);

    // qualification is lost the moment the control is let go
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adj_cnt <= '0;
        end else if (!i_adjust_held) begin
            adj_cnt <= '0;
        end else if (tick && (adj_cnt != HOLD_TICKS)) begin
            adj_cnt <= adj_cnt + 5'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fb_state        <= FB_IDLE;
            fb_cnt          <= '0;
            o_fold_shutdown <= 1'b0;
        end else begin
            case (fb_state)
                FB_IDLE: begin
                    fb_cnt <= '0;
                    if (fb_match) begin
                        fb_state <= FB_COUNT;
                    end
                end
                FB_COUNT: begin
                    if (!fb_match) begin
                        fb_state <= FB_IDLE;
                        fb_cnt   <= '0;
                    end else if (tick) begin
                        if (fb_cnt + 9'h1 >= fold_delay) begin
                            fb_state        <= FB_TRIP;
                            o_fold_shutdown <= 1'b1;
                        end else begin
                            fb_cnt <= fb_cnt + 9'h1;
                        end
                    end
                end
                FB_TRIP: begin
                    if (release_ok) begin
                        fb_state        <= FB_IDLE;
                        o_fold_shutdown <= 1'b0;
                    end
                end
                default: begin
                    fb_state        <= FB_IDLE;
                    o_fold_shutdown <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // alarms
    // ------------------------------------------------------------
    logic otp_hold;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            otp_hold <= 1'b0;
        end else if (i_otp_fault && otp_latch) begin
            otp_hold <= 1'b1;
        end else if (clr_cmd) begin
            otp_hold <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_otp_alarm       <= 1'b0;
            o_ilk_alarm       <= 1'b0;
            o_alarm_status    <= '0;
            o_shdn_active_low <= 1'b0;
        end else begin
            o_otp_alarm       <= i_otp_fault || otp_hold;
            o_ilk_alarm       <= i_ilk_fault && o_ilk_en;
            o_shdn_active_low <= o_loop_en ? 1'b1 : user_pol;
            o_alarm_status           <= '0;
            o_alarm_status[BIT_AC]   <= i_ac_fault;
            o_alarm_status[BIT_OTP]  <= i_otp_fault || otp_hold;
            o_alarm_status[BIT_FAN]  <= i_fan_fault && mask[BIT_FAN];
            o_alarm_status[BIT_ILK]  <= i_ilk_fault && o_ilk_en;
            o_alarm_status[BIT_OV]   <= i_ov_fault;
            o_alarm_status[BIT_OC]   <= i_oc_fault;
            o_alarm_status[BIT_FOLD] <= o_fold_shutdown && mask[BIT_FOLD];
            o_alarm_status[BIT_SHDN] <= i_shdn_fault && mask[BIT_SHDN];
            o_alarm_status[BIT_UV]   <= i_uv_fault && mask[BIT_UV];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    fold_trip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (fb_state == FB_COUNT) && fb_match && tick && (fb_cnt + 9'h1 >= fold_delay)
        |=> o_fold_shutdown)
        else $error("foldback did not trip at delay expiry");
    fold_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_fold_shutdown && !release_ok |=> o_fold_shutdown)
        else $error("foldback released without qualified clear");
    fold_mode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        fold_mode != 2'h3)
        else $error("illegal foldback mode");
    fold_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (fold_delay >= DELAY_MIN) && (fold_delay <= DELAY_MAX))
        else $error("foldback delay out of range");
    otp_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_otp_fault |=> o_otp_alarm && o_alarm_status[BIT_OTP])
        else $error("over-temperature alarm not raised");
    otp_latch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_otp_fault && otp_latch ##1 !i_otp_fault && !clr_cmd |=> o_otp_alarm)
        else $error("latched over-temperature alarm dropped");
    loop_query_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cmd_valid && i_cmd_query && (i_cmd_code == CMD_LOOP)
        |=> o_rsp_valid && (o_rsp_data == {10'h000, $past(o_loop_en)}))
        else $error("loop enable query answer wrong");
    loop_pol_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_loop_en |=> o_shdn_active_low)
        else $error("shutdown polarity not forced low active");
    ilk_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ilk_fault && o_ilk_en |=> o_ilk_alarm)
        else $error("interlock alarm not raised");
    mask_sup_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !mask[BIT_UV] |=> !o_alarm_status[BIT_UV])
        else $error("masked alarm reported");
    mask_fixed_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((mask & ~MASK_WRITABLE) == MASK_FIXED_ONES))
        else $error("fixed mask bits wrong");
    fold_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (fb_state == FB_COUNT) && !fb_match |=> !o_fold_shutdown && (fb_cnt == 9'h0))
        else $error("foldback abort did not reset count");
endmodule
`default_nettype wire

//--- spa_host.sv
// host model that issues text-style commands as single words
`timescale 1ns/1ps
`default_nettype none
module spa_host import spa_pkg::*; (
    input  wire logic        i_clk,   // system clock
    output logic             o_valid, // command strobe
    output logic             o_query, // query flag
    output logic [3:0]       o_code,  // command code
    output logic [10:0]      o_data,  // argument
    output logic [1:0]       o_sel    // level / source selector
);
    logic [11:0] q[$];
    initial begin
        o_valid = 1'b0;
        o_query = 1'b0;
        o_code  = 4'h0;
        o_data  = 11'h000;
        o_sel   = 2'h0;
    end
    // one idle cycle between commands keeps a command from landing on a recall load cycle, where the load wins and the write is dropped
    task automatic send(input logic [3:0] c, input logic qy, input logic [10:0] d,
                        input logic [11:0] e);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_query <= qy;
        o_code  <= c;
        o_data  <= d;
        q.push_back(e);
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_data  <= ~d; // released argument scrambled
    endtask
    // selector is left standing; commands that ignore it are unaffected
    task automatic send_sel(input logic [1:0] s, input logic [3:0] c, input logic qy,
                            input logic [10:0] d, input logic [11:0] e);
        o_sel <= s;
        send(c, qy, d, e);
    endtask
endmodule
`default_nettype wire

//--- tb_spa_top.sv
// self-checking bench for the protection and alarm control block
`timescale 1ns/1ps
`default_nettype none
module tb_spa_top;
    import spa_pkg::*;
    logic i_clk = 0, i_rst_n = 0, i_adj = 0, i_out_on = 0, i_reg_cc = 0, i_reg_cv = 0, v, qy;
    logic [3:0] cd;
    logic [10:0] dt, o_rsp_data;
    logic [7:0] flt = 8'h00;
    logic o_rsp_valid, o_rsp_err, o_fold, o_otp, o_pol;
    logic ilk, le, ie;
    logic [1:0] sel;
    logic [2:0] vsr, isr;
    logic [10:0] st;
    logic [27:0] lv;
    int miscompares = 0, n_tests = 0;
    logic [31:0] rnd = 32'h3ADA82A8;
    always #2.5 i_clk = ~i_clk;
    spa_host host (.i_clk(i_clk), .o_valid(v), .o_query(qy), .o_code(cd), .o_data(dt),
        .o_sel(sel));
    spa_top #(.TICK_CYCLES(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(v),
        .i_cmd_query(qy), .i_cmd_code(cd), .i_cmd_sel(sel), .i_cmd_data(dt),
        .i_out_on(i_out_on), .i_reg_cc(i_reg_cc), .i_reg_cv(i_reg_cv), .i_adjust_held(i_adj),
        .i_ac_fault(flt[0]), .i_otp_fault(flt[1]), .i_fan_fault(flt[2]), .i_ilk_fault(flt[3]),
        .i_ov_fault(flt[4]), .i_oc_fault(flt[5]), .i_shdn_fault(flt[6]), .i_uv_fault(flt[7]),
        .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err), .o_rsp_data(o_rsp_data),
        .o_fold_shutdown(o_fold), .o_otp_alarm(o_otp), .o_ilk_alarm(ilk), .o_alarm_status(st),
        .o_shdn_active_low(o_pol), .o_loop_en(le), .o_ilk_en(ie), .o_vsrc(vsr), .o_isrc(isr),
        .o_levels(lv));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge i_clk) if (o_rsp_valid === 1'b1) begin
        if (host.q.size() == 0) chk("unasked answer", 12'h000, 12'hFFF);
        else chk("answer", host.q.pop_front(), {o_rsp_err, o_rsp_data});
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        miscompares++;
        results();
    end
    initial begin
        int k;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        host.send(CMD_LOOP, 1, 0, 12'h000);
        host.send(CMD_MASK, 1, 0, {1'b0, MASK_RESET});
        host.send(CMD_LOOP, 0, 1, 12'h000);
        host.send(CMD_LOOP, 1, 0, 12'h001);
        chk("polarity", 12'h001, {11'h0, o_pol});
        chk("loop enable", 12'h001, {11'h0, le});
        host.send(CMD_LOOP, 0, 0, 12'h000);
        host.send(CMD_FOLD_DELAY, 0, 11'h004, 12'h800);
        host.send(CMD_FOLD_DELAY, 0, 11'h1F5, 12'h800);
        chk("polarity", 12'h000, {11'h0, o_pol});
        host.send(CMD_SHDN_POL, 0, 1, 12'h000);
        host.send(CMD_LOOP, 0, 1, 12'h000);
        host.send(CMD_LOOP, 0, 0, 12'h000);
        repeat (2) @(posedge i_clk);
        chk("user polarity", 12'h001, {11'h0, o_pol});
        host.send(CMD_RECALL, 0, 0, 12'h800);
        host.send(CMD_SAVE, 0, 4, 12'h800);
        host.send(CMD_FOLD_MODE, 0, 3, 12'h800);
        host.send(CMD_FOLD_MODE, 1, 0, {3'h0, 7'h0, FOLD_NONE});
        host.send(CMD_FOLD_MODE, 0, FOLD_CC, 12'h000);
        i_out_on <= 1'b1;
        i_reg_cc <= 1'b1;
        repeat (12) @(posedge i_clk);
        i_reg_cc <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reg_cc <= 1'b1;
        for (k = 0; k < 40 && o_fold !== 1'b1; k++) @(posedge i_clk);
        chk("fold trip", 12'h001, {11'h0, o_fold});
        chk("fold restart", 12'h001, {11'h0, k > 12});
        i_reg_cc <= 1'b0;
        host.send(CMD_PROT_CLEAR, 0, 0, 12'h000);
        @(posedge i_clk);
        chk("fold held", 12'h001, {11'h0, o_fold});
        i_adj <= 1'b1;
        repeat (130) @(posedge i_clk);
        host.send(CMD_PROT_CLEAR, 0, 0, 12'h000);
        @(posedge i_clk);
        chk("fold release", 12'h000, {11'h0, o_fold});
        host.send(CMD_FOLD_MODE, 0, FOLD_CV, 12'h000);
        i_reg_cv <= 1'b1;
        for (k = 0; k < 40 && o_fold !== 1'b1; k++) @(posedge i_clk);
        chk("cv trip", 12'h001, {11'h0, o_fold});
        i_reg_cv <= 1'b0;
        host.send(CMD_PROT_CLEAR, 0, 0, 12'h000);
        @(posedge i_clk);
        chk("cv release", 12'h000, {11'h0, o_fold});
        rnd = lfsr(rnd);
        host.send(CMD_MASK, 0, rnd[10:0], 12'h000);
        host.send(CMD_MASK, 1, 0, {1'b0, rnd[10:0] & MASK_WRITABLE | MASK_FIXED_ONES});
        host.send(CMD_MASK, 0, 0, 12'h000);
        flt <= 8'h02;
        repeat (3) @(posedge i_clk);
        chk("otp alarm", 12'h001, {11'h0, o_otp});
        host.send(CMD_INTERLOCK, 0, 1, 12'h000);
        flt <= 8'h8E;
        repeat (3) @(posedge i_clk);
        chk("ilk alarm", 12'h001, {11'h0, ilk});
        chk("ilk enable", 12'h001, {11'h0, ie});
        chk("masked status", 12'h022, {1'b0, st});
        host.send(CMD_MASK, 0, 11'h7FF, 12'h000);
        repeat (2) @(posedge i_clk);
        chk("open status", 12'h42A, {1'b0, st});
        host.send(CMD_OTP_LATCH, 0, 1, 12'h000);
        @(posedge i_clk);
        flt <= 8'h00;
        repeat (3) @(posedge i_clk);
        chk("otp latched", 12'h001, {11'h0, o_otp});
        host.send(CMD_PROT_CLEAR, 0, 0, 12'h000);
        repeat (2) @(posedge i_clk);
        chk("otp cleared", 12'h000, {11'h0, o_otp});
        host.send_sel(2'h2, CMD_LEVEL, 0, 11'h013, 12'h800);
        host.send_sel(2'h2, CMD_LEVEL, 0, 11'h014, 12'h000);
        host.send_sel(2'h1, CMD_SOURCE, 0, 11'h004, 12'h000);
        host.send_sel(2'h0, CMD_SOURCE, 0, 11'h002, 12'h000);
        host.send_sel(2'h2, CMD_SOURCE, 0, 11'h001, 12'h800);
        host.send_sel(2'h0, CMD_SOURCE, 0, 11'h005, 12'h800);
        chk("volt level", {5'h0, LEVEL_RESET}, {5'h0, lv[27:21]});
        chk("curr level", 12'h014, {5'h0, lv[13:7]});
        chk("sources", 12'h022, {6'h0, isr, vsr});
        host.send(CMD_SAVE, 0, 2, 12'h000);
        host.send(CMD_FOLD_DELAY, 0, DELAY_MAX, 12'h000);
        host.send_sel(2'h2, CMD_LEVEL, 0, LEVEL_MAX, 12'h000);
        host.send(CMD_RECALL, 0, 2, 12'h000);
        host.send(CMD_FOLD_DELAY, 1, 0, {3'h0, DELAY_RESET});
        host.send_sel(2'h2, CMD_LEVEL, 1, 0, 12'h014);
        results();
    end
endmodule
`default_nettype wire
